// ### adcrc_pkg.sv
// Constants of the converter channel, result and compare register block
package adcrc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CHSEL    = 8'h00;
    localparam logic [7:0] OFF_RES_WORD = 8'h04;
    localparam logic [7:0] OFF_RES_HIGH = 8'h08;
    localparam logic [7:0] OFF_CMP_MODE = 8'h0C;
    localparam logic [7:0] OFF_THRESH   = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_RUN_CTRL = 8'h1C;
    // Field positions and result widths
    localparam int B_EDGE_HI   = 7;
    localparam int B_EDGE_LO   = 6;
    localparam int B_HW_START  = 5;
    localparam int B_HW_SRC    = 4;
    localparam int B_CMP_EN    = 7;
    localparam int B_CMP_POL   = 6;
    localparam int B_RUN       = 0;
    localparam int B_SCAN      = 1;
    localparam int B_IRQ_END   = 0;
    localparam int B_IRQ_DONE  = 1;
    localparam int RES_W       = 10;
    localparam int RES_PAD     = 6;
    // Reset values
    localparam logic [7:0] CHSEL_RST = 8'h00;
    localparam logic [7:0] CMP_RST   = 8'h00;
    localparam logic [7:0] THR_RST   = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [1:0] IRQ_RST   = 2'h0;
    // Writable bit masks and first scan channel
    localparam logic [7:0] CHSEL_WMASK = 8'hF7;
    localparam logic [7:0] CMP_WMASK   = 8'hC0;
    localparam logic [7:0] THR_WMASK   = 8'hFF;
    localparam logic [7:0] CTRL_WMASK  = 8'h03;
    localparam logic [2:0] CH_FIRST    = 3'h0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Conversion time
    localparam int CONV_TIME_NS = 4000;
    localparam int CLK_MHZ      = 25;
    localparam int CONV_CYCLES  = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    // Engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } adcrc_state_t;
endpackage

// ### adcrc_top.sv
// Converter channel select, result, threshold compare and bus slave
// How it works
// - Channel register: 8 bits, resets zero
// - Channel field: single input or scan 0..n
// - Word result left-justified, low six zero
// - High byte returns result bits 9:2
// - Result registers have no reset value
// - Result code loaded from converter code
// - Compare mode register: 8 bits, low zero
// - Bit 7 enables threshold compare
// - Compare uses high result byte only
// - Bit 6 picks at-or-above or below
// - Compare off: interrupt every conversion end
// - Threshold register: 8 bits, resets zero
// - External valid edge starts a conversion
// - Timer compare event starts a conversion
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module adcrc_top #(
    parameter int ADDR_W   = 8,
    parameter int CONV_CYC = adcrc_pkg::CONV_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [9:0]        analog_code,
    input  wire logic              external_trigger_pin,
    input  wire logic              timer_compare_event,
    output logic [2:0]             analog_sel,
    output logic                   sample_active,
    output logic                   conversion_end_irq,
    output logic                   irq
);
    // Byte-lane merge of a write into an 8-bit register
    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] data,
                                          input logic en, input logic [7:0] wmask);
        merge8 = en ? (data & wmask) : old;
    endfunction

    logic               rst_meta_q;
    logic               rst_n_q;
    logic               aw_free_q;
    logic               w_free_q;
    logic [ADDR_W-1:0]  awaddr_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;
    logic               bvalid_q;
    logic [1:0]         bresp_q;
    logic               ar_free_q;
    logic               rvalid_q;
    logic [31:0]        rdata_q;
    logic [1:0]         rresp_q;
    logic [7:0]         chsel_q;
    logic [7:0]         cmp_q;
    logic [7:0]         thr_q;
    logic [7:0]         ctrl_q;
    logic [1:0]         stat_q;
    logic [1:0]         stat_d;
    logic [1:0]         mask_q;
    logic [9:0]         result_q;
    adcrc_pkg::adcrc_state_t state_q;
    adcrc_pkg::adcrc_state_t state_d;
    logic [15:0]        cnt_q;
    logic [15:0]        cnt_d;
    logic [2:0]         chan_q;
    logic [2:0]         chan_d;
    logic               pin_prev_q;
    logic               sel_active_q;
    logic [2:0]         sel_q;
    logic               end_pulse_q;
    logic               irq_q;

    // Reset release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'h0;
            rst_n_q    <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Write address decode
    wire wr_go    = !aw_free_q && !w_free_q && !bvalid_q;
    wire lane0    = wstrb_q[0];
    wire ws_chsel = wr_go && (awaddr_q == ADDR_W'(adcrc_pkg::OFF_CHSEL));
    wire ws_cmp   = wr_go && (awaddr_q == ADDR_W'(adcrc_pkg::OFF_CMP_MODE));
    wire ws_thr   = wr_go && (awaddr_q == ADDR_W'(adcrc_pkg::OFF_THRESH));
    wire ws_stat  = wr_go && (awaddr_q == ADDR_W'(adcrc_pkg::OFF_IRQ_STAT));
    wire ws_mask  = wr_go && (awaddr_q == ADDR_W'(adcrc_pkg::OFF_IRQ_MASK));
    wire ws_ctrl  = wr_go && (awaddr_q == ADDR_W'(adcrc_pkg::OFF_RUN_CTRL));
    wire ws_res   = wr_go && ((awaddr_q == ADDR_W'(adcrc_pkg::OFF_RES_WORD)) ||
                              (awaddr_q == ADDR_W'(adcrc_pkg::OFF_RES_HIGH)));
    wire wr_hit   = ws_chsel || ws_cmp || ws_thr || ws_stat || ws_mask || ws_ctrl || ws_res;
    wire cfg_wr   = (ws_chsel || ws_cmp || ws_thr || ws_ctrl) && lane0;

    // Result views
    wire [15:0] res_word = {result_q, adcrc_pkg::RES_PAD'(0)};
    wire [7:0]  res_high = result_q[9:2];

    // Read mux
    wire [7:0] ra = 8'(s_axi_araddr);
    wire ar_ok = s_axi_araddr == ADDR_W'(ra);
    wire rs_chsel = ar_ok && ra == adcrc_pkg::OFF_CHSEL;
    wire rs_word  = ar_ok && ra == adcrc_pkg::OFF_RES_WORD;
    wire rs_high  = ar_ok && ra == adcrc_pkg::OFF_RES_HIGH;
    wire rs_cmp   = ar_ok && ra == adcrc_pkg::OFF_CMP_MODE;
    wire rs_thr   = ar_ok && ra == adcrc_pkg::OFF_THRESH;
    wire rs_stat  = ar_ok && ra == adcrc_pkg::OFF_IRQ_STAT;
    wire rs_mask  = ar_ok && ra == adcrc_pkg::OFF_IRQ_MASK;
    wire rs_ctrl  = ar_ok && ra == adcrc_pkg::OFF_RUN_CTRL;
    wire rd_hit   = rs_chsel || rs_word || rs_high || rs_cmp || rs_thr ||
                    rs_stat || rs_mask || rs_ctrl;
    wire [31:0] rd_word = rs_chsel ? 32'(chsel_q) :
                          rs_word  ? 32'(res_word) :
                          rs_high  ? 32'(res_high) :
                          rs_cmp   ? 32'(cmp_q) :
                          rs_thr   ? 32'(thr_q) :
                          rs_stat  ? 32'(stat_q) :
                          rs_mask  ? 32'(mask_q) :
                          rs_ctrl  ? 32'(ctrl_q) : 32'h0;

    // Write channel capture and response
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            aw_free_q <= 1'h1;
            w_free_q  <= 1'h1;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'h0;
            bresp_q   <= adcrc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && aw_free_q) begin
                aw_free_q <= 1'h0;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && w_free_q) begin
                w_free_q <= 1'h0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_free_q <= 1'h1;
                w_free_q  <= 1'h1;
                bvalid_q  <= 1'h1;
                bresp_q   <= wr_hit ? adcrc_pkg::RESP_OKAY : adcrc_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'h0;
            end
        end
    end

    // Read channel
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ar_free_q <= 1'h1;
            rvalid_q  <= 1'h0;
            rdata_q   <= 32'h0;
            rresp_q   <= adcrc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && ar_free_q) begin
            ar_free_q <= 1'h0;
            rvalid_q  <= 1'h1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_hit ? adcrc_pkg::RESP_OKAY : adcrc_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            ar_free_q <= 1'h1;
            rvalid_q  <= 1'h0;
        end
    end

    // Control and configuration registers
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            chsel_q <= adcrc_pkg::CHSEL_RST;
            cmp_q   <= adcrc_pkg::CMP_RST;
            thr_q   <= adcrc_pkg::THR_RST;
            ctrl_q  <= adcrc_pkg::CTRL_RST;
            mask_q  <= adcrc_pkg::IRQ_RST;
        end else begin
            chsel_q <= merge8(chsel_q, wdata_q[7:0], ws_chsel && lane0,
                              adcrc_pkg::CHSEL_WMASK);
            cmp_q   <= merge8(cmp_q, wdata_q[7:0], ws_cmp && lane0,
                              adcrc_pkg::CMP_WMASK);
            thr_q   <= merge8(thr_q, wdata_q[7:0], ws_thr && lane0,
                              adcrc_pkg::THR_WMASK);
            ctrl_q  <= merge8(ctrl_q, wdata_q[7:0], ws_ctrl && lane0,
                              adcrc_pkg::CTRL_WMASK);
            if (ws_mask && lane0) begin
                mask_q <= wdata_q[1:0];
            end
        end
    end

    // Mode decode
    wire       run     = ctrl_q[adcrc_pkg::B_RUN];
    wire       scan    = ctrl_q[adcrc_pkg::B_SCAN];
    wire       hw      = chsel_q[adcrc_pkg::B_HW_START];
    wire       tsrc    = chsel_q[adcrc_pkg::B_HW_SRC];
    wire [2:0] ch_top  = chsel_q[2:0];
    wire       rise    = external_trigger_pin && !pin_prev_q;
    wire       fall    = !external_trigger_pin && pin_prev_q;
    wire       ext_hit = (chsel_q[adcrc_pkg::B_EDGE_HI] && rise) ||
                         (chsel_q[adcrc_pkg::B_EDGE_LO] && fall);
    wire       trig    = hw && (tsrc ? timer_compare_event : ext_hit);
    wire [2:0] ch_first = scan ? adcrc_pkg::CH_FIRST : ch_top;
    wire       more     = scan && (chan_q < ch_top);
    wire       last     = cnt_q == 16'(CONV_CYC - 1);
    wire       done     = (state_q == adcrc_pkg::ST_CONV) && run && !cfg_wr && !trig && last;

    // Threshold compare on the new high byte
    wire [7:0] new_high = analog_code[9:2];
    wire       cmp_en   = cmp_q[adcrc_pkg::B_CMP_EN];
    wire       cmp_hit  = cmp_q[adcrc_pkg::B_CMP_POL] ? (new_high < thr_q) :
                                                        (new_high >= thr_q);
    wire       fire     = done && (!cmp_en || cmp_hit);

    // Conversion sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 16'h1;
        chan_d  = chan_q;
        case (state_q)
            adcrc_pkg::ST_IDLE: begin
                cnt_d = 16'h0;
                if (run && !cfg_wr && (!hw || trig)) begin
                    state_d = adcrc_pkg::ST_CONV;
                    chan_d  = ch_first;
                end
            end
            adcrc_pkg::ST_CONV: begin
                if (!run) begin
                    state_d = adcrc_pkg::ST_IDLE;
                end else if (cfg_wr) begin
                    cnt_d  = 16'h0;
                    chan_d = ch_first;
                    if (hw) begin
                        state_d = adcrc_pkg::ST_IDLE;
                    end
                end else if (trig) begin
                    cnt_d  = 16'h0;
                    chan_d = ch_first;
                end else if (last) begin
                    cnt_d  = 16'h0;
                    chan_d = more ? chan_q + 3'h1 : ch_first;
                    if (hw && !more) begin
                        state_d = adcrc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = adcrc_pkg::ST_IDLE;
                cnt_d   = 16'h0;
            end
        endcase
    end

    // Sequencer and output flops
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q      <= adcrc_pkg::ST_IDLE;
            cnt_q        <= 16'h0;
            chan_q       <= 3'h0;
            pin_prev_q   <= 1'h0;
            sel_active_q <= 1'h0;
            sel_q        <= 3'h0;
            end_pulse_q  <= 1'h0;
        end else begin
            state_q      <= state_d;
            cnt_q        <= cnt_d;
            chan_q       <= chan_d;
            pin_prev_q   <= external_trigger_pin;
            sel_active_q <= state_d == adcrc_pkg::ST_CONV;
            sel_q        <= chan_d;
            end_pulse_q  <= fire;
        end
    end

    // Result latch, no reset by design; bus writes never reach it
    always_ff @(posedge clk) begin
        if (done) begin
            result_q <= analog_code;
        end
    end

    // Sticky status, set beats write-one clear
    wire [1:0] stat_set = {done, fire};
    wire [1:0] stat_clr = (ws_stat && lane0) ? wdata_q[1:0] : 2'h0;
    assign stat_d = (stat_q & ~stat_clr) | stat_set;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stat_q <= adcrc_pkg::IRQ_RST;
            irq_q  <= 1'h0;
        end else begin
            stat_q <= stat_d;
            irq_q  <= |(stat_d & mask_q);
        end
    end

    // Port drive
    assign s_axi_awready      = aw_free_q;
    assign s_axi_wready       = w_free_q;
    assign s_axi_bvalid       = bvalid_q;
    assign s_axi_bresp        = bresp_q;
    assign s_axi_arready      = ar_free_q;
    assign s_axi_rvalid       = rvalid_q;
    assign s_axi_rdata        = rdata_q;
    assign s_axi_rresp        = rresp_q;
    assign analog_sel         = sel_q;
    assign sample_active      = sel_active_q;
    assign conversion_end_irq = end_pulse_q;
    assign irq                = irq_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    property p_chsel_fixed;
        chsel_q[3] == 1'h0;
    endproperty
    a_chsel_fixed: assert property (p_chsel_fixed) else $error("channel bit 3 set");

    property p_cmp_fixed;
        cmp_q[5:0] == 6'h0;
    endproperty
    a_cmp_fixed: assert property (p_cmp_fixed) else $error("compare low bits set");

    property p_word_view;
        rs_word && s_axi_arvalid && ar_free_q |=>
            s_axi_rvalid && s_axi_rdata == {16'h0, $past(result_q), 6'h0};
    endproperty
    a_word_view: assert property (p_word_view) else $error("word view wrong");

    property p_high_view;
        rs_high && s_axi_arvalid && ar_free_q |=>
            s_axi_rvalid && s_axi_rdata[7:0] == $past(result_q[9:2]);
    endproperty
    a_high_view: assert property (p_high_view) else $error("high view wrong");

    property p_load;
        done |=> result_q == $past(analog_code) && conversion_end_irq == $past(fire);
    endproperty
    a_load: assert property (p_load) else $error("result not loaded");

    property p_ge_irq;
        done && cmp_en && !cmp_q[adcrc_pkg::B_CMP_POL] && analog_code[9:2] >= thr_q
            |=> conversion_end_irq && stat_q[adcrc_pkg::B_IRQ_END];
    endproperty
    a_ge_irq: assert property (p_ge_irq) else $error("missed at-or-above irq");

    property p_lt_block;
        done && cmp_en && cmp_q[adcrc_pkg::B_CMP_POL] && analog_code[9:2] >= thr_q
            |=> !conversion_end_irq;
    endproperty
    a_lt_block: assert property (p_lt_block) else $error("spurious below irq");

    property p_no_cmp;
        done && !cmp_en |=> conversion_end_irq;
    endproperty
    a_no_cmp: assert property (p_no_cmp) else $error("irq missing");

    property p_timer_start;
        state_q == adcrc_pkg::ST_IDLE && run && hw && tsrc && !cfg_wr && timer_compare_event
            |=> state_q == adcrc_pkg::ST_CONV && cnt_q == 16'h0 && sample_active;
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer start lost");

    property p_ext_start;
        state_q == adcrc_pkg::ST_IDLE && run && hw && !tsrc && !cfg_wr && ext_hit
            |=> state_q == adcrc_pkg::ST_CONV;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("edge start lost");

    property p_res_ro;
        ws_res && !done |=> $stable(result_q);
    endproperty
    a_res_ro: assert property (p_res_ro) else $error("result written");
endmodule

// ### adcrc_conv_model.sv
// Behavioural model of the analog converter facing the register block
`timescale 1ns/1ns
module adcrc_conv_model (
    input  wire logic       clk,
    input  wire logic [2:0] analog_sel,
    input  wire logic       sample_active,
    output logic      [9:0] analog_code
);
    logic [9:0] idle_q = 10'h155;

    // Code per channel while sampling, toggling junk otherwise
    assign analog_code = sample_active ? {analog_sel, 7'h2B} : idle_q;

    // Released code lines never hold the last value
    always @(posedge clk) begin
        idle_q <= ~idle_q;
    end
endmodule

// ### adcrc_top_bench.sv
// Testbench for the channel, result and compare register block
`timescale 1ns/1ns
module adcrc_top_bench;
    localparam logic [15:0] CMP_TAB [5] = '{16'h80AA, 16'h80AB, 16'hC0AB, 16'hC0AA, 16'h00FF};
    localparam logic [4:0]  CMP_HIT     = 5'b10101;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        ext_pin = 1'b0;
    logic        tmr_evt = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [9:0]  analog_code;
    logic [2:0]  analog_sel;
    logic        sample_active, conversion_end_irq, irq;
    int          miscompares = 0;
    int          n_tests = 0;
    int          ends = 0;
    int          e0;
    logic [7:0]  seen = 8'h00;
    logic [1:0]  r;
    logic [31:0] d;

    adcrc_top #(.CONV_CYC(4)) i_adcrc_top (
        .clk(clk), .nrst(nrst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_code(analog_code),
        .external_trigger_pin(ext_pin), .timer_compare_event(tmr_evt),
        .analog_sel(analog_sel), .sample_active(sample_active),
        .conversion_end_irq(conversion_end_irq), .irq(irq));

    adcrc_conv_model i_adcrc_conv_model (
        .clk(clk), .analog_sel(analog_sel), .sample_active(sample_active),
        .analog_code(analog_code));

    // Clock
    always #20 clk = ~clk;

    // Channels converted and end pulses, sampled away from the active edge
    always @(negedge clk) begin
        if (sample_active === 1'b1) seen = seen | (8'h01 << analog_sel);
        if (conversion_end_irq === 1'b1) ends = ends + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic expire;
        miscompares++;
        close_out();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Write cycle: address and data offered together, each released when taken
    task automatic wr_resp(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        if (s_axi_bvalid !== 1'b1) expire();
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] rs;
        wr_resp(a, v, rs);
    endtask

    // Read cycle: address released when taken, ready held until the answer is sampled
    task automatic rd_resp(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        if (s_axi_rvalid !== 1'b1) expire();
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0]  rs;
        rd_resp(a, v, rs);
        chk(v, exp);
    endtask

    // Poll status until any conversion end is flagged
    task automatic poll_end;
        logic [31:0] v;
        logic [1:0]  rs;
        int          n;
        n = 0;
        do begin
            rd_resp(adcrc_pkg::OFF_IRQ_STAT, v, rs);
            n++;
        end while (v[1] !== 1'b1 && n < 40);
        if (v[1] !== 1'b1) expire();
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sample_active !== 1'b0 && n < 200);
        if (sample_active !== 1'b0) expire();
    endtask

    // Main sequence
    initial begin
        tick(12);
        nrst <= 1'b1;
        tick(3);
        rd_chk(adcrc_pkg::OFF_CHSEL, 32'h0);
        rd_chk(adcrc_pkg::OFF_CMP_MODE, 32'h0);
        rd_chk(adcrc_pkg::OFF_THRESH, 32'h0);
        rd_chk(adcrc_pkg::OFF_IRQ_MASK, 32'h0);
        $display("test reset values done");
        wr(adcrc_pkg::OFF_CHSEL, 32'hFF);
        rd_chk(adcrc_pkg::OFF_CHSEL, 32'hF7);
        wr(adcrc_pkg::OFF_CMP_MODE, 32'hFF);
        rd_chk(adcrc_pkg::OFF_CMP_MODE, 32'hC0);
        wr(adcrc_pkg::OFF_THRESH, 32'h5A);
        rd_chk(adcrc_pkg::OFF_THRESH, 32'h5A);
        wr_resp(8'h20, 32'h1, r);
        chk({30'h0, r}, {30'h0, adcrc_pkg::RESP_SLVERR});
        rd_resp(8'h20, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, adcrc_pkg::RESP_SLVERR});
        wr(adcrc_pkg::OFF_CHSEL, 32'h05);
        wr(adcrc_pkg::OFF_CMP_MODE, 32'h0);
        $display("test register access done");
        wr(adcrc_pkg::OFF_RUN_CTRL, 32'h1);
        poll_end();
        chk({29'h0, analog_sel}, 32'h5);
        chk({31'h0, irq}, 32'h0);
        wr(adcrc_pkg::OFF_RUN_CTRL, 32'h0);
        wait_idle();
        rd_chk(adcrc_pkg::OFF_RES_WORD, 32'hAAC0);
        rd_chk(adcrc_pkg::OFF_RES_HIGH, 32'hAA);
        wr(adcrc_pkg::OFF_RES_WORD, 32'hFFFF);
        wr(adcrc_pkg::OFF_RES_HIGH, 32'hFF);
        rd_chk(adcrc_pkg::OFF_RES_WORD, 32'hAAC0);
        rd_chk(adcrc_pkg::OFF_RES_HIGH, 32'hAA);
        rd_chk(adcrc_pkg::OFF_IRQ_STAT, 32'h3);
        wr(adcrc_pkg::OFF_IRQ_MASK, 32'h3);
        tick(1);
        chk({31'h0, irq}, 32'h1);
        wr(adcrc_pkg::OFF_IRQ_STAT, 32'h3);
        tick(1);
        rd_chk(adcrc_pkg::OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test select mode done");
        for (int i = 0; i < 5; i++) begin
            wr(adcrc_pkg::OFF_CMP_MODE, {24'h0, CMP_TAB[i][15:8]});
            wr(adcrc_pkg::OFF_THRESH, {24'h0, CMP_TAB[i][7:0]});
            wr(adcrc_pkg::OFF_IRQ_STAT, 32'h3);
            e0 = ends;
            wr(adcrc_pkg::OFF_RUN_CTRL, 32'h1);
            poll_end();
            wr(adcrc_pkg::OFF_RUN_CTRL, 32'h0);
            wait_idle();
            tick(2);
            rd_chk(adcrc_pkg::OFF_IRQ_STAT, {30'h0, 1'b1, CMP_HIT[i]});
            chk({31'h0, ends != e0}, {31'h0, CMP_HIT[i]});
        end
        $display("test threshold compare done");
        wr(adcrc_pkg::OFF_CMP_MODE, 32'h0);
        wr(adcrc_pkg::OFF_CHSEL, 32'h32);
        wr(adcrc_pkg::OFF_RUN_CTRL, 32'h3);
        tick(3);
        chk({31'h0, sample_active}, 32'h0);
        seen = 8'h00;
        e0 = ends;
        tmr_evt <= 1'b1;
        @(posedge clk);
        tmr_evt <= 1'b0;
        tick(3);
        wait_idle();
        tick(2);
        chk({24'h0, seen}, 32'h07);
        chk(ends - e0, 32'd3);
        rd_chk(adcrc_pkg::OFF_RES_HIGH, 32'h4A);
        $display("test timer scan done");
        wr(adcrc_pkg::OFF_RUN_CTRL, 32'h1);
        for (int e = 0; e < 4; e++) begin
            wr(adcrc_pkg::OFF_CHSEL, {24'h0, e[1:0], 6'h21});
            e0 = ends;
            ext_pin <= 1'b1;
            tick(12);
            chk({31'h0, ends != e0}, {31'h0, e[1]});
            ext_pin <= 1'b0;
            tick(12);
            chk(ends - e0, e[1] + e[0]);
        end
        $display("test external edges done");
        close_out();
    end
endmodule
